/* design/quad_wiper_i2c_master.sv */
// Master end: read-data FIFO and two-wire bus sequencer
`timescale 1ns/1ps
`default_nettype none
`include "quad_wiper_cfg.svh"
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   // Storage written at the tail
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   // Pointers and fill level; wrap assumes a power-of-two depth
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         wrPtr <= wrPtr + AW'(push);
         rdPtr <= rdPtr + AW'(pop);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module quad_wiper_i2c_master #(
   parameter logic [3:0] DEV_TYPE = 4'ha, // Arbitrary type code
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   quad_wiper_if.host bus,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic cmdRead,
   input wire logic [2:0] cmdStrap,
   input wire logic [7:0] cmdAddr,
   input wire logic [7:0] cmdData,
   input wire logic [7:0] cmdLen,
   output logic rdValid,
   input wire logic rdReady,
   output logic [7:0] rdData,
   output logic done,
   output logic nack
);
   quad_wiper_pkg::host_state_t state;
   quad_wiper_pkg::host_seq_t seq;
   logic [1:0] sdaSync;
   logic [7:0] phCnt;
   logic tick;
   logic [1:0] ph;
   logic [3:0] bitIdx;
   logic [7:0] txByte;
   logic [7:0] rxByte;
   logic [7:0] rdLeft;
   logic isRead;
   logic [2:0] strap;
   logic [7:0] addr;
   logic [7:0] wrData;
   logic sclOut;
   logic sdaOeB;
   logic fifoPush;
   logic fifoReady;
   logic [7:0] fifoIn;
   logic stall;

   assign bus.hostScl = sclOut;
   assign bus.hostSdaOut = 1'b0;
   assign bus.hostSdaOeB = sdaOeB;
   assign cmdReady = (state == quad_wiper_pkg::H_IDLE);

   // Read bytes pile up here; a full FIFO holds the clock low
   sync_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_sync_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .inValid(fifoPush),
      .inReady(fifoReady),
      .inData(fifoIn),
      .outValid(rdValid),
      .outReady(rdReady),
      .outData(rdData)
   );

   // Data line comes back from the pins through two flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sdaSync <= 2'h3;
      end else begin
         sdaSync <= {sdaSync[0], bus.sda};
      end
   end

   // Quarter-period tick divided from clk
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phCnt <= 8'h00;
      end else begin
         phCnt <= tick ? 8'h00 : phCnt + 8'h01;
      end
   end
   assign tick = (phCnt == 8'(`SCL_PH_CYC - 1));
   // Only own pushes fill the FIFO, so space checked here stays
   assign stall = (seq == quad_wiper_pkg::S_RD) && (bitIdx == 4'h0) && !fifoReady;

   // Bus sequencer: ph0 clock low, ph1 set data, ph2 clock high, ph3 sample
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= quad_wiper_pkg::H_IDLE;
         seq <= quad_wiper_pkg::S_IDW;
         ph <= 2'h0;
         bitIdx <= 4'h0;
         txByte <= 8'h00;
         rxByte <= 8'h00;
         rdLeft <= 8'h00;
         isRead <= 1'b0;
         strap <= 3'h0;
         addr <= 8'h00;
         wrData <= 8'h00;
         sclOut <= 1'b1;
         sdaOeB <= 1'b1;
         fifoPush <= 1'b0;
         fifoIn <= 8'h00;
         done <= 1'b0;
         nack <= 1'b0;
      end else begin
         fifoPush <= 1'b0;
         done <= 1'b0;
         if (state == quad_wiper_pkg::H_IDLE) begin
            if (cmdValid) begin
               isRead <= cmdRead;
               strap <= cmdStrap;
               addr <= cmdAddr;
               wrData <= cmdData;
               rdLeft <= (cmdLen == 8'h00) ? 8'h01 : cmdLen;
               // reads first write the address, direction zero
               txByte <= {DEV_TYPE, cmdStrap, 1'b0};
               seq <= quad_wiper_pkg::S_IDW;
               bitIdx <= 4'h0;
               nack <= 1'b0;
               state <= quad_wiper_pkg::H_START;
            end
         end else if (tick) begin
            unique case (state)
               quad_wiper_pkg::H_START: begin
                  sdaOeB <= 1'b0;
                  ph <= 2'h0;
                  state <= quad_wiper_pkg::H_BIT;
               end
               quad_wiper_pkg::H_BIT: begin
                  ph <= stall ? ph : ph + 2'h1;
                  unique case (ph)
                     2'h0: sclOut <= 1'b0;
                     2'h1: begin
                        // data moves only with clock low
                        if (bitIdx < `BYTE_BITS) begin
                           sdaOeB <= (seq == quad_wiper_pkg::S_RD) | txByte[7];
                        end else begin
                           // ack all but the last read byte
                           sdaOeB <= !((seq == quad_wiper_pkg::S_RD) && rdLeft != 8'h01);
                        end
                     end
                     2'h2: sclOut <= 1'b1;
                     default: begin
                        if (bitIdx < `BYTE_BITS) begin
                           rxByte <= {rxByte[6:0], sdaSync[1]};
                           txByte <= {txByte[6:0], 1'b0};
                           bitIdx <= bitIdx + 4'h1;
                        end else begin
                           bitIdx <= 4'h0;
                           unique case (seq)
                              quad_wiper_pkg::S_RD: begin
                                 fifoPush <= 1'b1;
                                 fifoIn <= rxByte;
                                 rdLeft <= rdLeft - 8'h01;
                                 if (rdLeft == 8'h01) begin
                                    state <= quad_wiper_pkg::H_STOP;
                                 end
                              end
                              quad_wiper_pkg::S_IDW: begin
                                 txByte <= addr;
                                 seq <= quad_wiper_pkg::S_ADDR;
                              end
                              quad_wiper_pkg::S_ADDR: begin
                                 txByte <= wrData;
                                 seq <= quad_wiper_pkg::S_DATA;
                                 if (isRead) begin
                                    state <= quad_wiper_pkg::H_RSTART;
                                 end
                              end
                              quad_wiper_pkg::S_IDR: begin
                                 seq <= quad_wiper_pkg::S_RD;
                              end
                              default: begin
                                 // write closes after one data byte
                                 state <= quad_wiper_pkg::H_STOP;
                              end
                           endcase
                           // no ack from device aborts with STOP
                           if (seq != quad_wiper_pkg::S_RD && sdaSync[1]) begin
                              nack <= 1'b1;
                              state <= quad_wiper_pkg::H_STOP;
                           end
                        end
                     end
                  endcase
               end
               quad_wiper_pkg::H_RSTART: begin
                  ph <= ph + 2'h1;
                  unique case (ph)
                     2'h0: sclOut <= 1'b0;
                     2'h1: sdaOeB <= 1'b1;
                     2'h2: sclOut <= 1'b1;
                     default: begin
                        // repeated START, then id with direction one
                        sdaOeB <= 1'b0;
                        txByte <= {DEV_TYPE, strap, 1'b1};
                        seq <= quad_wiper_pkg::S_IDR;
                        state <= quad_wiper_pkg::H_BIT;
                     end
                  endcase
               end
               quad_wiper_pkg::H_STOP: begin
                  ph <= ph + 2'h1;
                  unique case (ph)
                     2'h0: sclOut <= 1'b0;
                     2'h1: sdaOeB <= 1'b0;
                     2'h2: sclOut <= 1'b1;
                     default: begin
                        // STOP: data rises with clock high
                        sdaOeB <= 1'b1;
                        done <= 1'b1;
                        state <= quad_wiper_pkg::H_IDLE;
                     end
                  endcase
               end
               default: state <= quad_wiper_pkg::H_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* design/quad_wiper_cfg.svh */
// Constants shared by both ends of the wiper control link
`ifndef QUAD_WIPER_CFG_SVH
`define QUAD_WIPER_CFG_SVH
`define NUM_CH 4
`define WIPER_RESET 8'h80
`define CLK_MHZ 200
`define PWRUP_NS 100
`define PWRUP_CYC ((`PWRUP_NS * `CLK_MHZ + 999) / 1000)
`define SCL_PH_NS 20
`define SCL_PH_CYC ((`SCL_PH_NS * `CLK_MHZ + 999) / 1000)
`define ID_TYPE_HI 7
`define ID_TYPE_LO 4
`define ID_STRAP_HI 3
`define ID_STRAP_LO 1
`define ID_RW 0
`define BYTE_BITS 4'h8
`endif

/* design/quad_wiper_pkg.sv */
// Types shared by both ends of the wiper control link
`default_nettype none
package quad_wiper_pkg;
   typedef enum logic [2:0] {D_IDLE, D_RX, D_RX_ACK, D_TX, D_TX_ACK} dev_state_t;
   typedef enum logic [1:0] {K_ID, K_ADDR, K_DATA} byte_kind_t;
   typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_RSTART, H_STOP} host_state_t;
   typedef enum logic [2:0] {S_IDW, S_ADDR, S_DATA, S_IDR, S_RD} host_seq_t;
endpackage
`default_nettype wire

/* design/quad_wiper_if.sv */
// Two-wire link between master and wiper device, with wired-AND data line
`timescale 1ns/1ps
`default_nettype none
interface quad_wiper_if;
   logic hostScl;
   logic hostSdaOut;
   logic hostSdaOeB;
   logic devSdaOut;
   logic devSdaOeB;
   logic scl;
   logic sda;
   // Pull-up wins unless an enabled driver pulls low
   assign scl = hostScl;
   assign sda = ~((~hostSdaOeB & ~hostSdaOut) | (~devSdaOeB & ~devSdaOut));
   modport device (input scl, input sda, output devSdaOut, output devSdaOeB);
   modport host (output hostScl, output hostSdaOut, output hostSdaOeB, input sda);
endinterface
`default_nettype wire

/* design/quad_wiper_i2c_slave.sv */
// Wiper device end: two-wire slave with four wiper position registers
`timescale 1ns/1ps
`default_nettype none
`include "quad_wiper_cfg.svh"
module quad_wiper_i2c_slave #(
   parameter logic [3:0] DEV_TYPE = 4'ha // Arbitrary type code
) (
   input wire logic clk,
   input wire logic rst_b,
   quad_wiper_if.device bus,
   input wire logic strap_addr_bit2,
   input wire logic strap_addr_bit1,
   input wire logic strap_addr_bit0,
   output logic [`NUM_CH-1:0][7:0] wiperPos
);
   quad_wiper_pkg::dev_state_t state;
   quad_wiper_pkg::byte_kind_t kind;
   logic [1:0] sclSync;
   logic [1:0] sdaSync;
   logic [2:0] strapSync0;
   logic [2:0] strapSync1;
   logic sclPrev;
   logic sdaPrev;
   logic sclRise;
   logic sclFall;
   logic startEv;
   logic stopEv;
   logic [7:0] pwrCnt;
   logic armed;
   logic [7:0] shift;
   logic [3:0] bitCnt;
   logic [1:0] ptr;
   logic readDir;
   logic masterAck;
   logic sdaOeB;
   logic storeData;

   // Identification byte check against type code and straps
   function automatic logic idMatch(input logic [7:0] idByte, input logic [2:0] strap);
      idMatch = (idByte[`ID_TYPE_HI:`ID_TYPE_LO] == DEV_TYPE) &&
                (idByte[`ID_STRAP_HI:`ID_STRAP_LO] == strap);
   endfunction

   // Only ever pull low; a high comes from the pull-up
   assign bus.devSdaOut = 1'b0;
   assign bus.devSdaOeB = sdaOeB;

   // Two-flop synchronisers for both lines and the straps
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sclSync <= 2'h3;
         sdaSync <= 2'h3;
         strapSync0 <= 3'h0;
         strapSync1 <= 3'h0;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclSync <= {sclSync[0], bus.scl};
         sdaSync <= {sdaSync[0], bus.sda};
         strapSync0 <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
         strapSync1 <= strapSync0;
         sclPrev <= sclSync[1];
         sdaPrev <= sdaSync[1];
      end
   end

   // Line events seen on the synchronised copies
   assign sclRise = sclSync[1] & ~sclPrev;
   assign sclFall = ~sclSync[1] & sclPrev;
   // start detect: data falls, clock high
   assign startEv = armed & sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
   // stop detect: data rises, clock high
   assign stopEv = armed & sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];

   // arm after power-up
   // A START during this window is dropped, not queued
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwrCnt <= 8'h00;
         armed <= 1'b0;
      end else if (!armed) begin
         pwrCnt <= pwrCnt + 8'h01;
         armed <= (pwrCnt == 8'(`PWRUP_CYC - 1));
      end
   end

   // store at the data byte's ack
   assign storeData = (state == quad_wiper_pkg::D_RX) && (kind == quad_wiper_pkg::K_DATA) &&
                      sclFall && (bitCnt == `BYTE_BITS);

   // Wiper registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < `NUM_CH; i++) begin
            wiperPos[i] <= `WIPER_RESET;
         end
      end else if (storeData) begin
         wiperPos[ptr] <= shift;
      end
   end

   // Byte sequencer, stepped by clock edges from the master
   // nothing moves without master edges
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= quad_wiper_pkg::D_IDLE;
         kind <= quad_wiper_pkg::K_ID;
         shift <= 8'h00;
         bitCnt <= 4'h0;
         ptr <= 2'h0;
         readDir <= 1'b0;
         masterAck <= 1'b0;
         sdaOeB <= 1'b1;
      end else if (startEv) begin
         // a START, repeated or not, restarts decoding
         state <= quad_wiper_pkg::D_RX;
         kind <= quad_wiper_pkg::K_ID;
         bitCnt <= 4'h0;
         sdaOeB <= 1'b1;
      end else if (stopEv) begin
         state <= quad_wiper_pkg::D_IDLE;
         sdaOeB <= 1'b1;
      end else begin
         unique case (state)
            quad_wiper_pkg::D_IDLE: begin
               sdaOeB <= 1'b1;
            end
            quad_wiper_pkg::D_RX: begin
               if (sclRise && bitCnt < `BYTE_BITS) begin
                  // first bit in lands at the top
                  shift <= {shift[6:0], sdaSync[1]};
                  bitCnt <= bitCnt + 4'h1;
               end else if (sclFall && bitCnt == `BYTE_BITS) begin
                  unique case (kind)
                     quad_wiper_pkg::K_ID: begin
                        if (idMatch(shift, strapSync1)) begin
                           readDir <= shift[`ID_RW];
                           sdaOeB <= 1'b0;
                           state <= quad_wiper_pkg::D_RX_ACK;
                        end else begin
                           state <= quad_wiper_pkg::D_IDLE;
                        end
                     end
                     quad_wiper_pkg::K_ADDR: begin
                        ptr <= shift[1:0];
                        sdaOeB <= 1'b0;
                        state <= quad_wiper_pkg::D_RX_ACK;
                     end
                     default: begin
                        sdaOeB <= 1'b0;
                        state <= quad_wiper_pkg::D_RX_ACK;
                     end
                  endcase
               end
            end
            quad_wiper_pkg::D_RX_ACK: begin
               if (sclFall) begin
                  // ack held for the ninth clock only
                  sdaOeB <= 1'b1;
                  bitCnt <= 4'h0;
                  unique case (kind)
                     quad_wiper_pkg::K_ID: begin
                        if (readDir) begin
                           // first byte from pointer, pointer steps
                           shift <= {wiperPos[ptr][6:0], 1'b0};
                           sdaOeB <= wiperPos[ptr][7];
                           ptr <= ptr + 2'h1;
                           bitCnt <= 4'h1;
                           state <= quad_wiper_pkg::D_TX;
                        end else begin
                           kind <= quad_wiper_pkg::K_ADDR;
                           state <= quad_wiper_pkg::D_RX;
                        end
                     end
                     quad_wiper_pkg::K_ADDR: begin
                        kind <= quad_wiper_pkg::K_DATA;
                        state <= quad_wiper_pkg::D_RX;
                     end
                     default: begin
                        state <= quad_wiper_pkg::D_IDLE;
                     end
                  endcase
               end
            end
            quad_wiper_pkg::D_TX: begin
               if (sclFall) begin
                  if (bitCnt == `BYTE_BITS) begin
                     sdaOeB <= 1'b1;
                     state <= quad_wiper_pkg::D_TX_ACK;
                  end else begin
                     sdaOeB <= shift[7];
                     shift <= {shift[6:0], 1'b0};
                     bitCnt <= bitCnt + 4'h1;
                  end
               end
            end
            quad_wiper_pkg::D_TX_ACK: begin
               if (sclRise) begin
                  masterAck <= ~sdaSync[1];
               end else if (sclFall) begin
                  if (masterAck) begin
                     shift <= {wiperPos[ptr][6:0], 1'b0};
                     sdaOeB <= wiperPos[ptr][7];
                     ptr <= ptr + 2'h1;
                     bitCnt <= 4'h1;
                     state <= quad_wiper_pkg::D_TX;
                  end else begin
                     state <= quad_wiper_pkg::D_IDLE;
                  end
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* bench/quad_wiper_monitor.sv */
// Concurrent checks on the two-wire link between master and wiper device
`timescale 1ns/1ps
`default_nettype none
`include "quad_wiper_cfg.svh"
module quad_wiper_monitor (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hostScl,
   input wire logic hostSdaOut,
   input wire logic hostSdaOeB,
   input wire logic devSdaOut,
   input wire logic devSdaOeB,
   input wire logic scl,
   input wire logic sda
);
   int pwrCnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Cycles since reset release; saturates so it never wraps into the guard again
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pwrCnt <= 0;
      end else if (pwrCnt < `PWRUP_CYC) begin
         pwrCnt <= pwrCnt + 1;
      end
   end
   a_pwrup_quiet: assert property (pwrCnt < `PWRUP_CYC |-> devSdaOeB)
      else $error("device drove data during power-up");
   a_dev_open_drain: assert property (devSdaOut == 1'b0)
      else $error("device data driver not open-drain");
   a_host_open_drain: assert property (hostSdaOut == 1'b0)
      else $error("master data driver not open-drain");
   // Device edges must sit well inside the low phase, or they read as START or STOP
   a_dev_edge_low: assert property ($changed(devSdaOeB) |-> !scl ##1 !scl ##1 !scl)
      else $error("device moved data near or during clock high");
   a_ack_hold: assert property ($fell(devSdaOeB) |-> !devSdaOeB [*8])
      else $error("device pull released too early");
   a_start_listen: assert property (scl && $fell(sda) |-> ##1 devSdaOeB [*8])
      else $error("device drove data right after start");
   a_stop_standby: assert property (scl && $rose(sda) |-> ##1 devSdaOeB [*8])
      else $error("device active after stop");
   a_scl_high_width: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   c_start: cover property (scl && $fell(sda) && !hostSdaOeB);
   c_stop: cover property (scl && $rose(sda));
   c_dev_pull: cover property ($fell(devSdaOeB));
endmodule
`default_nettype wire

/* bench/quad_wiper_i2c_slave_tb_top.sv */
// Self-checking bench joining master and wiper device over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module quad_wiper_i2c_slave_tb_top;
   localparam logic [2:0] STRAP = 3'h6;
   logic clk, rst_b, cmdValid, cmdRead, rdReady, cmdReady, rdValid, done, nack;
   logic [2:0] cmdStrap;
   logic [7:0] cmdAddr, cmdData, cmdLen, rdData;
   logic [3:0][7:0] wiperPos;
   logic [7:0] expW [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};
   int errTotal, checked, cycles, doneCnt, ops;
   quad_wiper_if u_link();
   quad_wiper_i2c_slave u_quad_wiper_i2c_slave (.clk(clk), .rst_b(rst_b), .bus(u_link.device),
      .strap_addr_bit2(STRAP[2]), .strap_addr_bit1(STRAP[1]), .strap_addr_bit0(STRAP[0]),
      .wiperPos(wiperPos));
   quad_wiper_i2c_master u_quad_wiper_i2c_master (.clk(clk), .rst_b(rst_b), .bus(u_link.host),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdStrap(cmdStrap),
      .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdLen(cmdLen), .rdValid(rdValid),
      .rdReady(rdReady), .rdData(rdData), .done(done), .nack(nack));
   quad_wiper_monitor u_quad_wiper_monitor (.clk(clk), .rst_b(rst_b),
      .hostScl(u_link.hostScl), .hostSdaOut(u_link.hostSdaOut), .hostSdaOeB(u_link.hostSdaOeB),
      .devSdaOut(u_link.devSdaOut), .devSdaOeB(u_link.devSdaOeB), .scl(u_link.scl),
      .sda(u_link.sda));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Done is a one-cycle pulse, so count it rather than poll for it
   always @(posedge clk) begin
      cycles++;
      if (done === 1'b1) doneCnt++;
      if (cycles == 60000) begin
         errTotal++;
         finishTest;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errTotal++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic send(input logic rd, input logic [2:0] st, input logic [7:0] a, d, n);
      @(negedge clk);
      cmdValid = 1'b1;
      cmdRead = rd;
      cmdStrap = st;
      cmdAddr = a;
      cmdData = d;
      cmdLen = n;
      @(negedge clk);
      cmdValid = 1'b0;
      ops++;
      // Command taken at the edge just passed, so the port is busy now
      chk({7'h00, cmdReady}, 8'h00);
   endtask
   task automatic waitDone;
      for (int k = 0; k < 20000 && doneCnt < ops; k++) @(negedge clk);
      chk(8'(doneCnt), 8'(ops));
      chk({7'h00, cmdReady}, 8'h01);
   endtask
   // Every channel written back to back, boundary values included
   task automatic testWrites;
      for (int i = 0; i < 4; i++) begin
         send(1'b0, STRAP, 8'(i), expW[i], 8'h00);
         waitDone;
         chk({7'h00, nack}, 8'h00);
         chk(wiperPos[i], expW[i]);
      end
   endtask
   // Reversed strap order must be refused and leave the wiper alone
   task automatic testBadId;
      send(1'b0, 3'h3, 8'h01, 8'h33, 8'h00);
      waitDone;
      chk({7'h00, nack}, 8'h01);
      chk(wiperPos[1], expW[1]);
   endtask
   // Long read from channel 2: fills the buffer, stalls the bus, then wraps
   task automatic testReadWrap;
      int k;
      send(1'b1, STRAP, 8'h02, 8'h00, 8'h12);
      repeat (4000) @(negedge clk);
      chk(8'(doneCnt), 8'(ops - 1));
      for (int i = 0; i < 18; i++) begin
         for (k = 0; k < 2000 && rdValid !== 1'b1; k++) @(negedge clk);
         chk(rdData, expW[(2 + i) % 4]);
         rdReady = 1'b1;
         @(negedge clk);
         rdReady = 1'b0;
      end
      waitDone;
      chk({7'h00, nack}, 8'h00);
   endtask
   // One-byte read with length code zero; address seven aliases channel 3
   task automatic testReadOne;
      send(1'b1, STRAP, 8'h07, 8'h00, 8'h00);
      waitDone;
      chk({7'h00, rdValid}, 8'h01);
      chk(rdData, expW[3]);
      rdReady = 1'b1;
      @(negedge clk);
      rdReady = 1'b0;
      // Exactly one byte came back before the master let go
      chk({7'h00, rdValid}, 8'h00);
      chk({7'h00, nack}, 8'h00);
   endtask
   task automatic finishTest;
      if (errTotal == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      rst_b = 1'b0;
      {cmdValid, cmdRead, rdReady, cmdAddr, cmdData, cmdLen} = '0;
      cmdStrap = STRAP;
      {errTotal, checked, cycles, doneCnt, ops} = '0;
      repeat (12) @(posedge clk);
      @(negedge clk) rst_b = 1'b1;
      repeat (24) @(negedge clk);
      for (int i = 0; i < 4; i++) chk(wiperPos[i], 8'h80);
      testWrites;
      testBadId;
      testReadWrap;
      testReadOne;
      finishTest;
   end
endmodule
`default_nettype wire
